// *** smsp_edge.sv ***
// synchronous edge detector for pins sampled on the core clock
`timescale 1ns/10ps
module smsp_edge (
	input wire logic i_clock, // core clock
	input wire logic i_rstn, // async reset, active low
	input wire logic i_level, // sampled pin level
	output logic o_rise, // one-cycle pulse on rising edge
	output logic o_fall, // one-cycle pulse on falling edge
	output logic o_level_q // delayed copy of the level
);
	logic prev_q;
	// idle high keeps a released pin from looking like an edge
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= i_level;
		end
	end
	assign o_rise = i_level & ~prev_q;
	assign o_fall = ~i_level & prev_q;
	assign o_level_q = prev_q;
endmodule

// *** smsp_host_model.sv ***
// host controller model that runs frames on the switch monitor serial port
`timescale 1ns/10ps
module smsp_host_model (
	input wire logic i_clock, // core clock
	input wire logic i_sdo, // serial data from the device
	input wire logic i_sdo_oe, // device output driver enable
	output logic o_select_n, // select, active low
	output logic o_sclk, // serial clock
	output logic o_sdi // serial data to the device
);
	// idle: deselected, clock parked low
	initial begin
		o_select_n = 1'b1;
		o_sclk = 1'b0;
		o_sdi = 1'b0;
	end
	// one whole 24-bit frame; select moves only while the clock is low
	task automatic xfer(input logic [23:0] cmd, output logic [23:0] got);
		int i;
		@(posedge i_clock) o_select_n <= 1'b0;
		repeat (4) @(posedge i_clock);
		for (i = 23; i >= 0; i--) begin
			@(posedge i_clock) o_sclk <= 1'b1;
			o_sdi <= cmd[i];
			repeat (4) @(posedge i_clock);
			// read just before the falling edge; a floating line reads unknown
			@(negedge i_clock) got[i] = i_sdo_oe ? i_sdo : 1'bx;
			@(posedge i_clock) o_sclk <= 1'b0;
			repeat (3) @(posedge i_clock);
		end
		@(posedge i_clock) o_select_n <= 1'b1;
		// the data line stops meaning anything once the frame is over
		o_sdi <= ~o_sdi;
		repeat (4) @(posedge i_clock);
	endtask
	// clock pulses with select high, which the device must ignore
	task automatic idle_clock(input int n);
		repeat (n) begin
			@(posedge i_clock) o_sclk <= 1'b1;
			repeat (2) @(posedge i_clock);
			@(posedge i_clock) o_sclk <= 1'b0;
			repeat (2) @(posedge i_clock);
		end
	endtask
endmodule

// *** smsp_pkg.sv ***
// shared constants for the switch monitor serial port
package smsp_pkg;
	localparam int unsigned WORD_BITS = 24;
	localparam int unsigned SP_COUNT = 8;
	localparam int unsigned SG_COUNT = 14;
	localparam int unsigned SW_COUNT = 22;
	localparam int unsigned RESET_FLAG_POS = 22;
	localparam int unsigned INT_FLAG_POS = 23;
	localparam logic [4:0] BIT_CNT_RESET = 5'h00;
	localparam logic [4:0] BIT_CNT_LAST = 5'h18;
	// command word layout: opcode in the top byte, data in the low bits
	localparam logic [7:0] CMD_SETTINGS = 8'h01;
	localparam int unsigned CMD_OP_LSB = 16;
	localparam logic [7:0] POLARITY_RESET = 8'hFF;
	localparam logic [21:0] INT_EN_RESET = 22'h3FFFFF;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b01,
		MODE_SLEEP = 2'b10
	} smsp_mode_type;
endpackage

// *** smsp_port.sv ***
// serial host port, interrupt and wake logic of the switch monitor
`timescale 1ns/10ps
module smsp_port (
	input wire logic i_clock, // core clock, 100 MHz
	input wire logic i_rstn, // async reset, active low
	input wire logic i_select_n, // host select, active low
	input wire logic i_sclk, // serial clock from host
	input wire logic i_sdi, // serial data in
	output logic o_sdo, // serial data out
	output logic o_sdo_oe, // serial out driver enable
	input wire logic i_int_n, // interrupt line level seen on the pin
	output logic o_int_oe, // pull interrupt line low
	input wire logic i_wake_n, // wake line level seen on the pin
	output logic o_wake_oe, // pull wake line low
	input wire logic i_logic_supply, // logic supply present
	input wire logic i_sleep_req, // request to enter sleep
	input wire logic [7:0] i_selectable_polarity_inputs, // above threshold
	input wire logic [13:0] i_ground_contact_inputs, // above threshold
	output logic [7:0] o_polarity_q, // 1 battery mode, 0 ground mode
	output logic [23:0] o_command_q, // last applied command word
	output logic o_command_stb, // one-cycle pulse on command apply
	output logic o_normal // normal mode indicator
);
	// ------------------------------------------------------------
	// edge detection
	// ------------------------------------------------------------
	logic sel_rise, sel_fall, sel_q;
	logic sck_rise, sck_fall;
	logic wake_fall, int_fall;
	smsp_edge u_sel (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_level(i_select_n),
		.o_rise(sel_rise),
		.o_fall(sel_fall),
		.o_level_q(sel_q)
	);
	smsp_edge u_sck (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_level(i_sclk),
		.o_rise(sck_rise),
		.o_fall(sck_fall),
		.o_level_q()
	);
	smsp_edge u_wake (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_level(i_wake_n),
		.o_rise(),
		.o_fall(wake_fall),
		.o_level_q()
	);
	smsp_edge u_int (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_level(i_int_n),
		.o_rise(),
		.o_fall(int_fall),
		.o_level_q()
	);

	// ------------------------------------------------------------
	// switch state decode
	// ------------------------------------------------------------
	logic [7:0] pol_q, pol_d;
	logic [21:0] sw_now, sw_last_q, int_en_q;
	logic sw_change, sw_armed_q;
	// battery mode: closed above threshold; ground mode: closed below
	assign sw_now[7:0] = ~(i_selectable_polarity_inputs ^ pol_q);
	// ground-only inputs are closed when low
	assign sw_now[21:8] = ~i_ground_contact_inputs;
	// compare against the last sampled states every cycle; the first
	// sample after reset only primes the history, so no false interrupt
	assign sw_change = sw_armed_q
		& |((sw_now ^ sw_last_q) & int_en_q);
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sw_last_q <= '0;
			sw_armed_q <= 1'b0;
		end else begin
			sw_last_q <= sw_now;
			sw_armed_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// mode control
	// ------------------------------------------------------------
	smsp_pkg::smsp_mode_type mode_q, mode_d;
	logic is_sleep, wake_ok, wake_evt;
	assign is_sleep = (mode_q == smsp_pkg::MODE_SLEEP);
	// without logic supply the interrupt line does not gate the wake pin
	assign wake_ok = wake_fall & (~i_logic_supply | i_int_n);
	assign wake_evt = wake_ok
		| (sel_fall & i_logic_supply)
		| (int_fall & i_wake_n & i_logic_supply)
		| sw_change;
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			smsp_pkg::MODE_NORMAL: begin
				if (i_sleep_req && sel_q) begin
					mode_d = smsp_pkg::MODE_SLEEP;
				end
			end
			smsp_pkg::MODE_SLEEP: begin
				if (wake_evt) begin
					mode_d = smsp_pkg::MODE_NORMAL;
				end
			end
			default: mode_d = smsp_pkg::MODE_NORMAL;
		endcase
	end

	// ------------------------------------------------------------
	// serial shifting
	// ------------------------------------------------------------
	logic [23:0] rx_q, tx_q;
	logic [4:0] cnt_q;
	logic rst_flag_q, int_pend_q, chg_during_q, sdo_q, sdo_oe_q;
	logic active;
	logic [23:0] status_word;
	// clock and data are only looked at while select is held low
	assign active = ~i_select_n & ~sel_fall;
	// msb: interrupt level, bit 22: reset flag, then switch states
	assign status_word = {~int_pend_q, rst_flag_q, sw_now};
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_q <= '0;
			tx_q <= '0;
			cnt_q <= smsp_pkg::BIT_CNT_RESET;
		end else if (sel_fall) begin
			tx_q <= status_word;
			cnt_q <= smsp_pkg::BIT_CNT_RESET;
		end else if (active && sck_fall) begin
			rx_q <= {rx_q[22:0], i_sdi};
			if (cnt_q != smsp_pkg::BIT_CNT_LAST) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end else if (active && sck_rise) begin
			tx_q <= {tx_q[22:0], 1'b0};
		end
	end
	// output drives the bit that the last rise exposed
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sdo_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			sdo_oe_q <= ~i_select_n & ~sel_rise;
			sdo_q <= (active && sck_rise) ? tx_q[23] : sdo_q;
		end
	end

	// ------------------------------------------------------------
	// command apply, interrupt and reset flag
	// ------------------------------------------------------------
	logic full_word, prog_ok, cmd_stb_q;
	logic [23:0] cmd_q;
	// partial words are dropped; programming only in normal with supply
	assign full_word = (cnt_q == smsp_pkg::BIT_CNT_LAST);
	assign prog_ok = sel_rise & full_word & ~is_sleep
		& i_logic_supply;
	always_comb begin
		pol_d = pol_q;
		if (prog_ok && rx_q[23:smsp_pkg::CMD_OP_LSB] ==
				smsp_pkg::CMD_SETTINGS) begin
			pol_d = rx_q[7:0];
		end
	end
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_q <= smsp_pkg::MODE_NORMAL;
			pol_q <= smsp_pkg::POLARITY_RESET;
			int_en_q <= smsp_pkg::INT_EN_RESET;
			cmd_q <= '0;
			cmd_stb_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			pol_q <= pol_d;
			cmd_stb_q <= prog_ok;
			if (prog_ok) begin
				cmd_q <= rx_q;
			end
		end
	end
	// change during select low keeps the interrupt; set beats clear
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			int_pend_q <= 1'b0;
			chg_during_q <= 1'b0;
			rst_flag_q <= 1'b1;
		end else begin
			if (sel_fall) begin
				chg_during_q <= 1'b0;
			end else if (!sel_q && sw_change) begin
				chg_during_q <= 1'b1;
			end
			if (sw_change && !is_sleep) begin
				int_pend_q <= 1'b1;
			end else if (sel_rise && !chg_during_q) begin
				int_pend_q <= 1'b0;
			end
			if (sel_rise) begin
				rst_flag_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	logic int_oe_q, wake_oe_q, normal_q;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			int_oe_q <= 1'b0;
			wake_oe_q <= 1'b0;
			normal_q <= 1'b0;
		end else begin
			int_oe_q <= int_pend_q;
			wake_oe_q <= ~is_sleep;
			normal_q <= ~is_sleep;
		end
	end
	assign o_sdo = sdo_q;
	assign o_sdo_oe = sdo_oe_q;
	assign o_int_oe = int_oe_q;
	assign o_wake_oe = wake_oe_q;
	assign o_polarity_q = pol_q;
	assign o_command_q = cmd_q;
	assign o_command_stb = cmd_stb_q;
	assign o_normal = normal_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	AST_SDO_OFF_HIGH: assert property (
		sel_q && i_select_n |=> !o_sdo_oe)
		else $error("serial out driven while select high");
	AST_SDO_ON_FALL: assert property (
		sel_fall |=> o_sdo_oe)
		else $error("serial out not enabled after select fall");
	AST_SDO_OFF_RISE: assert property (
		sel_rise |=> !o_sdo_oe)
		else $error("serial out not released at select rise");
	AST_CAPTURE: assert property (
		sel_fall |=> tx_q == $past(status_word))
		else $error("status word not captured");
	AST_CMD_APPLY: assert property (
		o_command_stb |-> $past(sel_rise))
		else $error("command applied away from select rise");
	AST_INT_HOLD: assert property (
		sel_rise && chg_during_q |=> int_pend_q)
		else $error("interrupt cleared despite change");
	AST_INT_SET: assert property (
		sw_change && !is_sleep |=> ##1 o_int_oe)
		else $error("interrupt not asserted on change");
	AST_WAKE_PIN: assert property (
		is_sleep [*2] |-> !o_wake_oe)
		else $error("wake pin driven in sleep");
	AST_RST_CLR: assert property (
		sel_rise |=> !rst_flag_q [*1])
		else $error("reset flag not cleared");
	AST_NO_PROG_SLEEP: assert property (
		(is_sleep || !i_logic_supply) && sel_rise
		|=> $stable(o_polarity_q) && !o_command_stb)
		else $error("programming outside normal mode");
	COV_TRANSFER: cover property (sel_fall ##[1:1000] sel_rise);
	COV_CMD: cover property (o_command_stb);
	COV_WAKE: cover property (is_sleep ##1 !is_sleep);
endmodule

// *** tb_top.sv ***
// self-checking bench for the switch monitor serial port
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0, rstn = 1'b0, ext_int = 1'b0, ext_wake = 1'b0;
	logic sup = 1'b1, slp = 1'b0;
	logic [7:0] sp = 8'h3C, pol = 8'hFF;
	logic [13:0] sg = 14'h1234;
	logic [23:0] got, e;
	logic sel_n, sclk, sdi, sdo, sdo_oe, int_oe, wake_oe, stb, normal;
	logic [7:0] pol_q;
	logic [23:0] cmd_q;
	int error_cnt = 0, checks_done = 0, stb_cnt = 0;
	// open-drain wires: anyone pulling wins
	wire int_n = ~(int_oe | ext_int);
	wire wake_n = ~(wake_oe | ext_wake);
	wire [1:0] watch = {int_oe, normal};
	always #5 clk = ~clk;
	always @(posedge clk) if (stb === 1'b1) stb_cnt++;
	smsp_port dut (.i_clock(clk), .i_rstn(rstn), .i_select_n(sel_n),
		.i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
		.i_int_n(int_n), .o_int_oe(int_oe), .i_wake_n(wake_n),
		.o_wake_oe(wake_oe), .i_logic_supply(sup), .i_sleep_req(slp),
		.i_selectable_polarity_inputs(sp), .i_ground_contact_inputs(sg),
		.o_polarity_q(pol_q), .o_command_q(cmd_q), .o_command_stb(stb),
		.o_normal(normal));
	smsp_host_model host (.i_clock(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
		.o_select_n(sel_n), .o_sclk(sclk), .o_sdi(sdi));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [23:0] g, input logic [23:0] x);
		checks_done++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	// bounded wait for interrupt (k=1) or normal mode (k=0)
	task automatic wt(input int k, input logic v);
		int n;
		for (n = 0; n < 60 && watch[k] !== v; n++) @(posedge clk);
		if (watch[k] !== v) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, watch[k], v);
			wrap_up();
		end
	endtask
	// closed reads one; selectable inputs follow their polarity setting
	function automatic logic [23:0] exp_word(logic il, logic rf);
		return {il, rf, ~sg, pol ~^ sp};
	endfunction
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_flag();
		host.idle_clock(3);
		chk({23'h0, sdo_oe}, 24'h0);
		host.xfer(24'h000000, got);
		chk(got, exp_word(1'b1, 1'b1));
		chk({23'h0, sdo_oe}, 24'h0);
		host.xfer(24'h000000, got);
		chk(got, exp_word(1'b1, 1'b0));
		$display("test reset_flag done");
	endtask
	task automatic t_settings();
		int n;
		n = stb_cnt;
		host.xfer(24'h0100A5, got);
		pol = 8'hA5;
		chk(cmd_q, 24'h0100A5);
		chk({16'h0, pol_q}, {16'h0, pol});
		chk(24'(stb_cnt - n), 24'h1);
		host.xfer(24'h000000, got);
		// new polarity changes the reported states, so the interrupt rises
		chk(got, exp_word(1'b0, 1'b0));
		$display("test settings done");
	endtask
	task automatic t_interrupt();
		@(posedge clk) sg <= sg ^ 14'h0001;
		wt(1, 1'b1);
		host.xfer(24'h000000, got);
		chk(got, exp_word(1'b0, 1'b0));
		chk({23'h0, int_oe}, 24'h0);
		e = exp_word(1'b1, 1'b0);
		fork
			host.xfer(24'h000000, got);
			begin
				repeat (40) @(posedge clk);
				sp <= sp ^ 8'h01;
			end
		join
		chk(got, e);
		chk({23'h0, int_oe}, 24'h1);
		host.xfer(24'h000000, got);
		chk(got, exp_word(1'b0, 1'b0));
		chk({23'h0, int_oe}, 24'h0);
		$display("test interrupt done");
	endtask
	// wake by wake line, select, shared interrupt, then a blocked wake
	task automatic t_sleep_wake();
		int k;
		for (k = 0; k < 4; k++) begin
			@(posedge clk) ext_int <= (k == 3);
			slp <= 1'b1;
			wt(0, 1'b0);
			chk({23'h0, wake_oe}, 24'h0);
			@(posedge clk) slp <= 1'b0;
			repeat (5) @(posedge clk);
			if (k == 1) host.xfer(24'h000000, got);
			if (k == 2) ext_int <= 1'b1;
			if (k == 3) begin
				ext_wake <= 1'b1;
				repeat (30) @(posedge clk);
				chk({23'h0, normal}, 24'h0);
				ext_wake <= 1'b0;
				ext_int <= 1'b0;
				repeat (5) @(posedge clk);
			end
			if (k != 1) ext_wake <= (k != 2);
			repeat (5) @(posedge clk);
			ext_int <= 1'b0;
			ext_wake <= (k == 3);
			wt(0, 1'b1);
			@(posedge clk) ext_wake <= 1'b0;
			repeat (3) @(posedge clk);
			chk({23'h0, wake_oe}, 24'h1);
		end
		$display("test sleep_wake done");
	endtask
	// no logic supply: programming refused, select cannot wake, wake pin
	// wakes even with the shared interrupt line held low
	task automatic t_no_supply();
		@(posedge clk) sup <= 1'b0;
		host.xfer(24'h01005A, got);
		chk({16'h0, pol_q}, {16'h0, pol});
		@(posedge clk) slp <= 1'b1;
		ext_int <= 1'b1;
		wt(0, 1'b0);
		@(posedge clk) slp <= 1'b0;
		host.xfer(24'h000000, got);
		chk({23'h0, normal}, 24'h0);
		@(posedge clk) ext_wake <= 1'b1;
		wt(0, 1'b1);
		@(posedge clk) ext_wake <= 1'b0;
		ext_int <= 1'b0;
		sup <= 1'b1;
		$display("test no_supply done");
	endtask
	// reset held for five cycles, then each scenario in turn
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_flag();
		t_settings();
		t_interrupt();
		t_sleep_wake();
		t_no_supply();
		wrap_up();
	end
endmodule
